// file: logic/fault_injection_register.sv
// Fault and warning injection word per page plus the fixed platform identity word.
// Assumes a bus front end that decodes word transactions into command, strobe and data.
//
// Notes on behaviour
// - Injection word at F1, word read and write.
// - One word per page, never stored in NVM.
// - Set bits force detectors; combinations allowed.
// - Bit 15 fault persistence, resets to zero.
// - Bit 7 warning persistence.
// - Bit 14 injects overtemperature fault.
// - Bit 12 injects output overcurrent fault.
// - Bit 11 injects input undervoltage lockout.
// - Bit 10 injects input overvoltage fault.
// - Bit 9 injects output undervoltage fault.
// - Bit 8 injects output overvoltage fault.
// - Bit 4 injects output overcurrent warning.
// - Bit 3 injects input undervoltage warning.
// - Bit 1 injects output undervoltage warning.
// - Bit 0 injects output overvoltage warning.
// - Lockout and output overvoltage fault act while disabled.
// - Other injections act only while enabled.
// - Read-only identity word at FC.
// - Identity writes acknowledged and discarded.
// - Identity writes raise no communication error.
`timescale 1ns/1ps
module fault_injection_register
  import fault_inject_pkg::*;
#(
  parameter int          PAGES       = 2,
  parameter logic [15:0] PLATFORM_ID = PLATFORM_ID_DEFAULT
) (
  input  wire logic                       clk_i,
  input  wire logic                       resetn_i,
  input  wire logic                       ce_i,
  input  wire logic                       cmd_valid_i,
  input  wire logic                       cmd_write_i,
  input  wire logic [7:0]                 cmd_code_i,
  input  wire logic [$clog2(PAGES)-1:0]   cmd_page_i,
  input  wire logic [15:0]                cmd_wdata_i,
  input  wire logic [PAGES-1:0]           conv_en_i,
  input  wire logic [PAGES-1:0]           fault_response_i,
  input  wire logic [PAGES-1:0]           warn_response_i,
  input  wire logic [PAGES*FAULT_W-1:0]   fault_real_i,
  input  wire logic [PAGES*WARN_W-1:0]    warn_real_i,
  output logic                            cmd_ack_o,
  output logic                            cmd_hit_o,
  output logic                            cmd_error_o,
  output logic      [15:0]                cmd_rdata_o,
  output logic      [PAGES*FAULT_W-1:0]   fault_flag_o,
  output logic      [PAGES*WARN_W-1:0]    warn_flag_o
);

  if (PAGES < 2 || PAGES > 8) begin : g_bad_pages
    $error("PAGES must be 2 to 8");
  end

  logic                 hit_inject;
  logic                 hit_id;
  logic [PAGES-1:0]     page_load;
  logic [FAULT_W-1:0]   fault_armed [PAGES];
  logic [WARN_W-1:0]    warn_armed  [PAGES];
  logic [PAGES-1:0]     fault_persist;
  logic [PAGES-1:0]     warn_persist;
  logic [FAULT_W-1:0]   fault_force [PAGES];
  logic [WARN_W-1:0]    warn_force  [PAGES];
  logic [15:0]          page_word   [PAGES];
  logic                 next_ack;
  logic                 next_hit;
  logic                 next_error;
  logic [15:0]          next_rdata;

  assign hit_inject = cmd_code_i == CMD_FAULT_INJECTION;
  assign hit_id     = cmd_code_i == CMD_PLATFORM_ID;

  genvar p;
  generate
    for (p = 0; p < PAGES; p++) begin : g_page
      assign page_load[p] = cmd_valid_i && cmd_write_i && hit_inject &&
                            (cmd_page_i == ($clog2(PAGES))'(p));

      inject_arm #(
        .W           (FAULT_W),
        .ALWAYS_MASK ({10'h000, FAULT_ALWAYS_MASK})
      ) u_fault (
        .clk_i          (clk_i),
        .resetn_i       (resetn_i),
        .ce_i           (ce_i),
        .load_i         (page_load[p]),
        .load_bits_i    (fault_bits(cmd_wdata_i)),
        .load_persist_i (cmd_wdata_i[BIT_FAULT_PERSIST]),
        .response_i     (fault_response_i[p]),
        .conv_en_i      (conv_en_i[p]),
        .armed_o        (fault_armed[p]),
        .force_o        (fault_force[p])
      );

      inject_arm #(
        .W           (WARN_W),
        .ALWAYS_MASK ({12'h000, WARN_ALWAYS_MASK})
      ) u_warn (
        .clk_i          (clk_i),
        .resetn_i       (resetn_i),
        .ce_i           (ce_i),
        .load_i         (page_load[p]),
        .load_bits_i    (warn_bits(cmd_wdata_i)),
        .load_persist_i (cmd_wdata_i[BIT_WARN_PERSIST]),
        .response_i     (warn_response_i[p]),
        .conv_en_i      (conv_en_i[p]),
        .armed_o        (warn_armed[p]),
        .force_o        (warn_force[p])
      );

      // Persistence bits are kept here too so the word reads back exactly.
      always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          fault_persist[p] <= INJECT_RESET[BIT_FAULT_PERSIST];
          warn_persist[p]  <= INJECT_RESET[BIT_WARN_PERSIST];
        end else if (ce_i && page_load[p]) begin
          fault_persist[p] <= cmd_wdata_i[BIT_FAULT_PERSIST];
          warn_persist[p]  <= cmd_wdata_i[BIT_WARN_PERSIST];
        end
      end

      always_comb begin
        page_word[p]                      = INJECT_RESET;
        page_word[p][BIT_FAULT_PERSIST]   = fault_persist[p];
        page_word[p][BIT_OVERTEMP_F]      = fault_armed[p][5];
        page_word[p][BIT_OVERCURRENT_F]   = fault_armed[p][4];
        page_word[p][BIT_IN_LOCKOUT]      = fault_armed[p][3];
        page_word[p][BIT_IN_OVERVOLT_F]   = fault_armed[p][2];
        page_word[p][BIT_OUT_UNDERVOLT_F] = fault_armed[p][1];
        page_word[p][BIT_OUT_OVERVOLT_F]  = fault_armed[p][0];
        page_word[p][BIT_WARN_PERSIST]    = warn_persist[p];
        page_word[p][BIT_OVERCURRENT_W]   = warn_armed[p][3];
        page_word[p][BIT_IN_UNDERVOLT_W]  = warn_armed[p][2];
        page_word[p][BIT_OUT_UNDERVOLT_W] = warn_armed[p][1];
        page_word[p][BIT_OUT_OVERVOLT_W]  = warn_armed[p][0];
      end

      // Forced flags join the real ones ahead of status and response logic.
      detector_merge #(
        .W (FAULT_W)
      ) u_fault_merge (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .ce_i     (ce_i),
        .real_i   (fault_real_i[p*FAULT_W +: FAULT_W]),
        .force_i  (fault_force[p]),
        .flag_o   (fault_flag_o[p*FAULT_W +: FAULT_W])
      );

      detector_merge #(
        .W (WARN_W)
      ) u_warn_merge (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .ce_i     (ce_i),
        .real_i   (warn_real_i[p*WARN_W +: WARN_W]),
        .force_i  (warn_force[p]),
        .flag_o   (warn_flag_o[p*WARN_W +: WARN_W])
      );
    end
  endgenerate

  // Reserved bits are not stored and read as zero.
  always_comb begin
    next_ack   = 1'b0;
    next_hit   = 1'b0;
    next_error = 1'b0;
    next_rdata = 16'h0000;
    if (cmd_valid_i) begin
      next_ack = 1'b1;
      if (hit_inject) begin
        next_hit = 1'b1;
        // A page number of PAGES or above reads zero instead of an unknown word.
        if (!cmd_write_i && 32'(cmd_page_i) < PAGES) begin
          next_rdata = page_word[cmd_page_i];
        end
      end else if (hit_id) begin
        next_hit = 1'b1;
        if (!cmd_write_i) begin
          next_rdata = PLATFORM_ID;
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cmd_ack_o   <= 1'b0;
      cmd_hit_o   <= 1'b0;
      cmd_error_o <= 1'b0;
      cmd_rdata_o <= 16'h0000;
    end else if (ce_i) begin
      cmd_ack_o   <= next_ack;
      cmd_hit_o   <= next_hit;
      cmd_error_o <= next_error;
      cmd_rdata_o <= next_rdata;
    end
  end

  // Checks; the bench drives page 0 conversion enable through conv_en_i.
  a_id_read_fixed: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ce_i && cmd_valid_i && !cmd_write_i && hit_id |=> cmd_rdata_o == PLATFORM_ID)
    else $error("identity read wrong");

  a_id_write_quiet: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ce_i && cmd_valid_i && cmd_write_i && hit_id |=> cmd_ack_o && !cmd_error_o)
    else $error("identity write flagged");

  a_id_write_noeff: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ce_i && cmd_valid_i && cmd_write_i && hit_id && !fault_response_i[0] && !warn_response_i[0]
    |=> $stable(page_word[0]))
    else $error("identity write changed state");

  a_write_readback: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ce_i && page_load[0] |=> page_word[0] == ($past(cmd_wdata_i) & 16'hDF9B))
    else $error("injection word not stored");

  a_page_separate: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ce_i && page_load[0] && !page_load[1] && !fault_response_i[1] && !warn_response_i[1]
    |=> $stable(page_word[1]))
    else $error("page leak");

  a_fault_autoclear: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ce_i && !fault_persist[0] && fault_response_i[0] && !page_load[0] |=> fault_armed[0] == '0)
    else $error("fault not cleared");

  a_fault_persist: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ce_i && fault_persist[0] && !page_load[0] |=> $stable(fault_armed[0]))
    else $error("persistent fault dropped");

  a_warn_autoclear: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ce_i && !warn_persist[0] && warn_response_i[0] && !page_load[0] |=> warn_armed[0] == '0)
    else $error("warning not cleared");

  a_disabled_gate: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ce_i && !conv_en_i[0] |=> (fault_force[0] & ~FAULT_ALWAYS_MASK) == '0 && warn_force[0] == '0)
    else $error("injection active while disabled");

  a_forced_flag: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ce_i && conv_en_i[0] && page_load[0] ##1 ce_i && !fault_response_i[0]
    |=> fault_flag_o[FAULT_W-1:0] == fault_bits(page_word[0]))
    else $error("forced flag missing");

  // Bit positions are checked one rule at a time so a swapped pair names its culprit.
  a_map_overtemp: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ce_i && page_load[0]
    |=> fault_armed[0][5] == $past(cmd_wdata_i[BIT_OVERTEMP_F]))
    else $error("overtemperature bit misplaced");

  a_map_overcurrent: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ce_i && page_load[0]
    |=> fault_armed[0][4] == $past(cmd_wdata_i[BIT_OVERCURRENT_F]))
    else $error("overcurrent fault bit misplaced");

  a_map_lockout: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ce_i && page_load[0]
    |=> fault_armed[0][3] == $past(cmd_wdata_i[BIT_IN_LOCKOUT]))
    else $error("lockout bit misplaced");

  a_map_input_ov: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ce_i && page_load[0]
    |=> fault_armed[0][2] == $past(cmd_wdata_i[BIT_IN_OVERVOLT_F]))
    else $error("input overvoltage bit misplaced");

  a_map_output_uv: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ce_i && page_load[0]
    |=> fault_armed[0][1] == $past(cmd_wdata_i[BIT_OUT_UNDERVOLT_F]))
    else $error("output undervoltage bit misplaced");

  a_map_output_ov: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ce_i && page_load[0]
    |=> fault_armed[0][0] == $past(cmd_wdata_i[BIT_OUT_OVERVOLT_F]))
    else $error("output overvoltage bit misplaced");

  a_map_oc_warn: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ce_i && page_load[0]
    |=> warn_armed[0][3] == $past(cmd_wdata_i[BIT_OVERCURRENT_W]))
    else $error("overcurrent warning bit misplaced");

  a_map_inuv_warn: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ce_i && page_load[0]
    |=> warn_armed[0][2] == $past(cmd_wdata_i[BIT_IN_UNDERVOLT_W]))
    else $error("input undervoltage warning bit misplaced");

  a_map_outuv_warn: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ce_i && page_load[0]
    |=> warn_armed[0][1] == $past(cmd_wdata_i[BIT_OUT_UNDERVOLT_W]))
    else $error("output undervoltage warning bit misplaced");

  a_map_outov_warn: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ce_i && page_load[0]
    |=> warn_armed[0][0] == $past(cmd_wdata_i[BIT_OUT_OVERVOLT_W]))
    else $error("output overvoltage warning bit misplaced");

  // Gating, persistence, merge and command-answer checks for page 0; page 1 only needs its read path.
  a_enabled_pass: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ce_i && conv_en_i[0]
    |=> fault_force[0] == fault_armed[0] && warn_force[0] == warn_armed[0])
    else $error("injection blocked while enabled");

  a_disabled_keep: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ce_i && !conv_en_i[0]
    |=> fault_force[0] == (fault_armed[0] & FAULT_ALWAYS_MASK))
    else $error("lockout or overvoltage lost while disabled");

  a_warn_persist: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ce_i && warn_persist[0] && !page_load[0]
    |=> $stable(warn_armed[0]))
    else $error("persistent warning dropped");

  a_merge_real: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ce_i
    |=> fault_flag_o[FAULT_W-1:0] == ($past(fault_real_i[FAULT_W-1:0]) | $past(fault_force[0])))
    else $error("real and forced faults not merged");

  a_hit_ack: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ce_i && cmd_valid_i && (hit_inject || hit_id)
    |=> cmd_ack_o && cmd_hit_o)
    else $error("known command not answered");

  a_unknown_miss: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ce_i && cmd_valid_i && !hit_inject && !hit_id
    |=> cmd_ack_o && !cmd_hit_o && cmd_rdata_o == 16'h0000)
    else $error("unknown command claimed");

  a_page_read: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ce_i && cmd_valid_i && !cmd_write_i && hit_inject && cmd_page_i == '0
    |=> cmd_rdata_o == $past(page_word[0]))
    else $error("page 0 read wrong");

  a_page_other: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ce_i && cmd_valid_i && !cmd_write_i && hit_inject && cmd_page_i == ($clog2(PAGES))'(1)
    |=> cmd_rdata_o == $past(page_word[1]))
    else $error("page 1 read wrong");

  a_warn_forced: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ce_i && conv_en_i[0] && page_load[0] ##1
    ce_i && !warn_response_i[0] && warn_real_i[WARN_W-1:0] == '0
    |=> warn_flag_o[WARN_W-1:0] == warn_bits(page_word[0]))
    else $error("forced warning missing");

  c_inject_enabled:  cover property (@(posedge clk_i) page_load[0] && conv_en_i[0] && cmd_wdata_i[14]);
  c_lockout_disabled: cover property (@(posedge clk_i) fault_force[0][3] && !conv_en_i[0]);
  c_persist_response: cover property (@(posedge clk_i) fault_persist[0] && fault_response_i[0]);
  c_id_write:        cover property (@(posedge clk_i) cmd_valid_i && cmd_write_i && hit_id);
  c_warn_autoclear:  cover property (@(posedge clk_i) !warn_persist[0] && warn_response_i[0] && warn_armed[0] != '0);

endmodule

// file: logic/fault_inject_pkg.sv
// Constants for the fault and warning injection block of a managed power converter.
// Assumes a command decoder upstream that delivers word reads and writes by command code.
package fault_inject_pkg;

  localparam logic [7:0]  CMD_FAULT_INJECTION = 8'hF1;
  localparam logic [7:0]  CMD_PLATFORM_ID     = 8'hFC;

  localparam int          WORD_W              = 16;
  localparam int          FAULT_W             = 6;
  localparam int          WARN_W              = 4;

  localparam int          BIT_FAULT_PERSIST   = 15;
  localparam int          BIT_OVERTEMP_F      = 14;
  localparam int          BIT_OVERCURRENT_F   = 12;
  localparam int          BIT_IN_LOCKOUT      = 11;
  localparam int          BIT_IN_OVERVOLT_F   = 10;
  localparam int          BIT_OUT_UNDERVOLT_F = 9;
  localparam int          BIT_OUT_OVERVOLT_F  = 8;
  localparam int          BIT_WARN_PERSIST    = 7;
  localparam int          BIT_OVERCURRENT_W   = 4;
  localparam int          BIT_IN_UNDERVOLT_W  = 3;
  localparam int          BIT_OUT_UNDERVOLT_W = 1;
  localparam int          BIT_OUT_OVERVOLT_W  = 0;

  localparam logic [15:0] INJECT_RESET        = 16'h0000;
  // Arbitrary neutral identity value.
  localparam logic [15:0] PLATFORM_ID_DEFAULT = 16'h5A01;

  // Fault vector order: overtemp, overcurrent, lockout, in-ov, out-uv, out-ov.
  localparam logic [5:0]  FAULT_ALWAYS_MASK   = 6'h09;
  localparam logic [3:0]  WARN_ALWAYS_MASK    = 4'h0;

  function automatic logic [5:0] fault_bits(input logic [15:0] w);
    return {w[BIT_OVERTEMP_F], w[BIT_OVERCURRENT_F], w[BIT_IN_LOCKOUT],
            w[BIT_IN_OVERVOLT_F], w[BIT_OUT_UNDERVOLT_F], w[BIT_OUT_OVERVOLT_F]};
  endfunction

  function automatic logic [3:0] warn_bits(input logic [15:0] w);
    return {w[BIT_OVERCURRENT_W], w[BIT_IN_UNDERVOLT_W], w[BIT_OUT_UNDERVOLT_W], w[BIT_OUT_OVERVOLT_W]};
  endfunction

endpackage

// file: logic/inject_arm.sv
// One group of injection bits with its persistence and auto-clear handling.
// Assumes the response strobe is one cycle long and comes from the fault response logic.
`timescale 1ns/1ps
module inject_arm
  import fault_inject_pkg::*;
#(
  parameter int          W           = 4,
  parameter logic [15:0] ALWAYS_MASK = 16'h0000
) (
  input  wire logic         clk_i,
  input  wire logic         resetn_i,
  input  wire logic         ce_i,
  input  wire logic         load_i,
  input  wire logic [W-1:0] load_bits_i,
  input  wire logic         load_persist_i,
  input  wire logic         response_i,
  input  wire logic         conv_en_i,
  output logic      [W-1:0] armed_o,
  output logic      [W-1:0] force_o
);

  if (W < 1 || W > 16) begin : g_bad_width
    $error("inject_arm width unsupported");
  end

  logic [W-1:0] armed;
  logic [W-1:0] next_armed;
  logic [W-1:0] next_force;
  logic         persist;
  logic         next_persist;

  always_comb begin
    next_armed   = armed;
    next_persist = persist;
    if (load_i) begin
      next_armed   = load_bits_i;
      next_persist = load_persist_i;
    end else if (response_i && !persist) begin
      next_armed = '0;
    end
    next_force = next_armed & (conv_en_i ? {W{1'b1}} : ALWAYS_MASK[W-1:0]);
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      armed   <= '0;
      persist <= 1'b0;
      force_o <= '0;
    end else if (ce_i) begin
      armed   <= next_armed;
      persist <= next_persist;
      force_o <= next_force;
    end
  end

  assign armed_o = armed;

endmodule

// file: logic/detector_merge.sv
// Merges real detector outputs with forced ones so both share one response path.
// Assumes detector inputs are synchronous flags from the analog front end.
`timescale 1ns/1ps
module detector_merge #(
  parameter int W = 6
) (
  input  wire logic         clk_i,
  input  wire logic         resetn_i,
  input  wire logic         ce_i,
  input  wire logic [W-1:0] real_i,
  input  wire logic [W-1:0] force_i,
  output logic      [W-1:0] flag_o
);

  logic [W-1:0] next_flag;

  always_comb begin
    next_flag = real_i | force_i;
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      flag_o <= '0;
    end else if (ce_i) begin
      flag_o <= next_flag;
    end
  end

endmodule

// file: bench/host_model.sv
// Host side model that issues decoded word reads and writes to the injection block.
// Assumes the block takes a one-cycle request and answers exactly one cycle later.
`timescale 1ns/1ps
module host_model #(
  parameter int PW = 1
) (
  input  wire logic          clk_i,
  output logic               cmd_valid_o,
  output logic               cmd_write_o,
  output logic [7:0]         cmd_code_o,
  output logic [PW-1:0]      cmd_page_o,
  output logic [15:0]        cmd_wdata_o,
  input  wire logic          cmd_ack_i,
  input  wire logic          cmd_hit_i,
  input  wire logic          cmd_error_i,
  input  wire logic [15:0]   cmd_rdata_i
);
  initial begin
    cmd_valid_o = 1'b0;
    cmd_write_o = 1'b0;
    cmd_code_o  = 8'h00;
    cmd_page_o  = '0;
    cmd_wdata_o = 16'h0000;
  end

  // Whole 16-bit words only, written or read back as one unit.
  task automatic xfer(input logic wr, input logic [7:0] code, input logic [PW-1:0] page,
                      input logic [15:0] wdata, output logic [18:0] resp);
    @(posedge clk_i);
    cmd_valid_o <= 1'b1;
    cmd_write_o <= wr;
    cmd_code_o  <= code;
    cmd_page_o  <= page;
    cmd_wdata_o <= wdata;
    @(posedge clk_i);
    cmd_valid_o <= 1'b0;
    // Released code and data lines show the inverse, so a design that samples late sees garbage.
    cmd_code_o  <= ~code;
    cmd_wdata_o <= ~wdata;
    // The answer stands for one cycle after the take edge, so it is read just after that edge.
    #1;
    resp = {cmd_ack_i, cmd_hit_i, cmd_error_i, cmd_rdata_i};
  endtask
endmodule

// file: bench/tb.sv
// Self-checking bench for the fault injection register with a host model on the command port.
// Assumes two pages and flags that follow a write or a response by two clock edges.
`timescale 1ns/1ps
module tb;
  import fault_inject_pkg::*;
  logic        clk_i;
  logic        resetn_i;
  logic        ce_i;
  logic        cmd_valid_i;
  logic        cmd_write_i;
  logic [7:0]  cmd_code_i;
  logic [0:0]  cmd_page_i;
  logic [15:0] cmd_wdata_i;
  logic [1:0]  conv_en_i;
  logic [1:0]  fault_response_i;
  logic [1:0]  warn_response_i;
  logic [11:0] fault_real_i;
  logic [7:0]  warn_real_i;
  logic        cmd_ack_o;
  logic        cmd_hit_o;
  logic        cmd_error_o;
  logic [15:0] cmd_rdata_o;
  logic [11:0] fault_flag_o;
  logic [7:0]  warn_flag_o;
  logic [18:0] resp;
  int          error_cnt;
  int          checks_done;
  int          bits [10] = '{14, 12, 11, 10, 9, 8, 4, 3, 1, 0};

  fault_injection_register #(.PAGES(2)) DUT (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i),
    .cmd_valid_i(cmd_valid_i), .cmd_write_i(cmd_write_i), .cmd_code_i(cmd_code_i),
    .cmd_page_i(cmd_page_i), .cmd_wdata_i(cmd_wdata_i), .conv_en_i(conv_en_i),
    .fault_response_i(fault_response_i), .warn_response_i(warn_response_i),
    .fault_real_i(fault_real_i), .warn_real_i(warn_real_i), .cmd_ack_o(cmd_ack_o),
    .cmd_hit_o(cmd_hit_o), .cmd_error_o(cmd_error_o), .cmd_rdata_o(cmd_rdata_o),
    .fault_flag_o(fault_flag_o), .warn_flag_o(warn_flag_o));

  host_model #(.PW(1)) host (.clk_i(clk_i), .cmd_valid_o(cmd_valid_i), .cmd_write_o(cmd_write_i),
    .cmd_code_o(cmd_code_i), .cmd_page_o(cmd_page_i), .cmd_wdata_o(cmd_wdata_i),
    .cmd_ack_i(cmd_ack_o), .cmd_hit_i(cmd_hit_o), .cmd_error_i(cmd_error_o), .cmd_rdata_i(cmd_rdata_o));

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  task automatic chk(input string what, input logic [19:0] seen, input logic [19:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic pulse(input logic [1:0] fw);
    @(posedge clk_i);
    fault_response_i <= {1'b0, fw[1]};
    warn_response_i  <= {1'b0, fw[0]};
    @(posedge clk_i);
    fault_response_i <= 2'b00;
    warn_response_i  <= 2'b00;
    step(2);
  endtask

  task automatic stop_test();
    if (error_cnt == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic t_reset();
    host.xfer(1'b0, 8'hF1, 1'b0, 16'h0000, resp);
    chk("inject word after reset", resp, 19'h60000);
    host.xfer(1'b0, 8'hFC, 1'b0, 16'h0000, resp);
    chk("identity read", resp, {3'b110, PLATFORM_ID_DEFAULT});
    host.xfer(1'b0, 8'h20, 1'b0, 16'h0000, resp);
    chk("unknown code", resp, 19'h40000);
  endtask

  task automatic t_map();
    for (int i = 0; i < 10; i++) begin
      host.xfer(1'b1, 8'hF1, 1'b0, 16'h8080 | (16'h0001 << bits[i]), resp);
      step(1);
      chk("fault flags", fault_flag_o, (i < 6) ? (6'h20 >> i) : 6'h00);
      chk("warn flags", warn_flag_o, (i > 5) ? (4'h8 >> (i - 6)) : 4'h0);
    end
    host.xfer(1'b1, 8'hF1, 1'b0, 16'hFFFF, resp);
    step(1);
    chk("all flags", {fault_flag_o, warn_flag_o}, 20'h03F0F);
    host.xfer(1'b0, 8'hF1, 1'b0, 16'h0000, resp);
    chk("stored bits", resp[15:0], 16'hDF9B);
    host.xfer(1'b0, 8'hF1, 1'b1, 16'h0000, resp);
    chk("other page word", resp[15:0], 16'h0000);
  endtask

  task automatic t_disabled();
    @(posedge clk_i);
    conv_en_i <= 2'b10;
    host.xfer(1'b1, 8'hF1, 1'b0, 16'hDF9B, resp);
    step(1);
    chk("disabled flags", {fault_flag_o[5:0], warn_flag_o[3:0]}, 10'h090);
    @(posedge clk_i);
    conv_en_i <= 2'b11;
    step(2);
    chk("enabled flags", {fault_flag_o[5:0], warn_flag_o[3:0]}, 10'h3FF);
  endtask

  task automatic t_autoclear();
    host.xfer(1'b1, 8'hF1, 1'b0, 16'h4010, resp);
    step(1);
    chk("one shot armed", {fault_flag_o[5:0], warn_flag_o[3:0]}, 10'h208);
    pulse(2'b10);
    chk("fault cleared", {fault_flag_o[5:0], warn_flag_o[3:0]}, 10'h008);
    pulse(2'b01);
    chk("warn cleared", warn_flag_o, 8'h00);
    host.xfer(1'b1, 8'hF1, 1'b0, 16'hC090, resp);
    pulse(2'b11);
    chk("persist kept", {fault_flag_o[5:0], warn_flag_o[3:0]}, 10'h208);
  endtask

  task automatic t_identity();
    host.xfer(1'b1, 8'hFC, 1'b0, 16'h1234, resp);
    chk("identity write answer", resp[18:16], 3'b110);
    host.xfer(1'b0, 8'hFC, 1'b1, 16'h0000, resp);
    chk("identity unchanged", resp[15:0], PLATFORM_ID_DEFAULT);
  endtask

  task automatic t_real();
    host.xfer(1'b1, 8'hF1, 1'b0, 16'h0000, resp);
    fault_real_i <= 12'h100;
    warn_real_i  <= 8'h02;
    step(2);
    chk("real paths", {fault_flag_o, warn_flag_o}, 20'h10002);
  endtask

  initial begin
    error_cnt = 0;
    checks_done = 0;
    resetn_i = 1'b0;
    ce_i = 1'b1;
    conv_en_i = 2'b11;
    fault_response_i = 2'b00;
    warn_response_i = 2'b00;
    fault_real_i = 12'h000;
    warn_real_i = 8'h00;
    repeat (20) @(posedge clk_i);
    resetn_i <= 1'b1;
    t_reset();
    t_map();
    t_disabled();
    t_autoclear();
    t_identity();
    t_real();
    stop_test();
  end

  // The whole run needs about a hundred cycles, so this limit only trips on a hang.
  initial begin
    #(3000 * 50);
    error_cnt++;
    stop_test();
  end
endmodule
